// ### inc/pwm_params.svh
/*
  timing and field constants for the two-channel compare/pwm block.
  assumes inclusion by bare name from the design files.
*/
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

`define CNT_W 16
`define PERIOD_RESET 16'hffff
`define EDGE_OFF 2'h0
`define EDGE_TOGGLE 2'h1
`define EDGE_CLEAR 2'h2
`define EDGE_SET 2'h3
`define MODE_UNBUF 2'h1
`define MODE_BUF 2'h2

`endif

// ### inc/pwm_pkg.sv
/*
  types shared by the compare/pwm block and its channel slice.
  assumes nothing beyond a standard systemverilog compiler.
*/
`default_nettype none
package pwm_pkg;
  // per-channel control bits as software sets them
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic edge_action_high;
    logic edge_action_low;
    logic toggle_on_wrap;
    logic full_duty_force;
  } chan_ctrl_s;

  typedef enum logic [1:0] {
    ACT_ZERO = 2'b01,
    ACT_ONE = 2'b10
  } active_e;
endpackage
`default_nettype wire

// ### src/pwm_chan_out.sv
/*
  one compare/pwm output slice: applies the compare action and wrap toggle to a pin level.
  assumes the counter, wrap pulse and compare value come from the same clock domain.
*/
`default_nettype none
`include "pwm_params.svh"
module pwm_chan_out #(
  parameter int W = `CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // timing inputs
  input wire logic tick,
  input wire logic wrap,
  input wire logic [W-1:0] count,
  input wire logic [W-1:0] cmp_value,
  // configuration
  input wire pwm_pkg::chan_ctrl_s ctrl,
  input wire logic enable,
  // results
  output logic level,
  output logic match
);
  import pwm_pkg::*;

  logic next_level;
  logic [1:0] edge_sel;
  logic [W-1:0] step_count;

  assign edge_sel = {ctrl.edge_action_high, ctrl.edge_action_low};
  // count taken at this edge; acting on it makes the pin move as the counter
  // reaches the value, not one count late. a clear while counting is not seen
  // here, so clear only with the counter halted
  assign step_count = wrap ? '0 : count + 1'b1;
  // compare uses the live register value: no shadow copy
  // live value only
  assign match = enable && tick && (step_count == cmp_value);

  // next pin level; wrap toggle first, compare action wins in the same count unless full duty is forced with the wrap toggle
  always_comb begin
    next_level = level;
    if (enable && wrap && ctrl.toggle_on_wrap) begin
      next_level = ~level;
      // forced full duty keeps the pulse level for the whole period
      if (ctrl.full_duty_force) begin
        next_level = ~edge_sel[0];
      end
    end
    if (match && !(ctrl.full_duty_force && ctrl.toggle_on_wrap)) begin
      case (edge_sel)
        `EDGE_CLEAR: next_level = 1'b0;
        `EDGE_SET: next_level = 1'b1;
        `EDGE_TOGGLE: next_level = ~next_level;
        default: next_level = next_level;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level <= 1'b0;
    end else begin
      level <= next_level;
    end
  end
endmodule // pwm_chan_out
`default_nettype wire

// ### src/timer_compare_pwm_channels.sv
/*
  counter, wrap event and two compare/pwm channels with optional buffered linking.
  assumes control and value ports are driven from sys_clk logic; tick is the
  prescaled count enable from the same domain.
*/
`default_nettype none
`include "pwm_params.svh"
module timer_compare_pwm_channels #(
  parameter int W = `CNT_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // counter control
  input wire logic tick,
  input wire logic counter_halt,
  input wire logic counter_clear,
  input wire logic [W-1:0] period_limit,
  // channel values and their write strobes
  input wire logic [W-1:0] channel_value0,
  input wire logic [W-1:0] channel_value1,
  input wire logic value1_written,
  input wire logic value0_written,
  // channel controls
  input wire pwm_pkg::chan_ctrl_s channel_zero_control,
  input wire pwm_pkg::chan_ctrl_s channel_one_control,
  // pins and status
  output logic channel_zero_pin,
  output logic channel_one_pin,
  output logic channel_one_pin_oe,
  output logic [W-1:0] count,
  output logic wrap_flag,
  output logic cmp0_event,
  output logic cmp1_event,
  output logic pair_linked,
  output logic set_one_active
);
  import pwm_pkg::*;

  logic [W-1:0] next_count;
  logic next_wrap_flag;
  active_e active, next_active;
  active_e pending, next_pending;
  logic run, wrap_now, linked;
  logic [W-1:0] cmp_zero;
  logic lvl0, lvl1, m0, m1;

  assign linked = channel_zero_control.mode_select_high;
  assign pair_linked = linked;
  assign run = tick && !counter_halt;
  assign wrap_now = run && (count == period_limit);

  // counter next value; clear wins so halt plus clear parks at zero
  always_comb begin
    next_count = count;
    next_wrap_flag = 1'b0;
    if (counter_clear) begin
      next_count = '0;
    end else if (run) begin
      next_count = wrap_now ? '0 : count + 1'b1;
      next_wrap_flag = wrap_now;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      wrap_flag <= 1'b0;
    end else begin
      count <= next_count;
      wrap_flag <= next_wrap_flag;
    end
  end

  always_comb begin
    next_active = active;
    next_pending = pending;
    if (!linked) begin
      next_active = ACT_ZERO;
      next_pending = ACT_ZERO;
    end else begin
      if (value1_written) begin
        next_pending = ACT_ONE;
      end else if (value0_written) begin
        next_pending = ACT_ZERO;
      end
      // a write in the wrap cycle itself is taken at that wrap
      if (wrap_now) begin
        next_active = next_pending;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      active <= ACT_ZERO;
      pending <= ACT_ZERO;
    end else begin
      active <= next_active;
      pending <= next_pending;
    end
  end

  assign set_one_active = (active == ACT_ONE);
  assign cmp_zero = (linked && active == ACT_ONE) ? channel_value1 : channel_value0;

  pwm_chan_out #(.W(W)) u_ch0 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick(run),
    .wrap(wrap_now),
    .count(count),
    .cmp_value(cmp_zero),
    .ctrl(channel_zero_control),
    .enable(1'b1),
    .level(lvl0),
    .match(m0)
  );

  pwm_chan_out #(.W(W)) u_ch1 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick(run),
    .wrap(wrap_now),
    .count(count),
    .cmp_value(channel_value1),
    .ctrl(channel_one_control),
    .enable(!linked),
    .level(lvl1),
    .match(m1)
  );

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmp0_event <= 1'b0;
      cmp1_event <= 1'b0;
    end else begin
      cmp0_event <= m0;
      cmp1_event <= m1;
    end
  end

  assign channel_zero_pin = lvl0;
  assign channel_one_pin = lvl1;
  assign channel_one_pin_oe = !linked;

  property p_wrap_zero;
    @(posedge sys_clk) disable iff (!nrst)
      (wrap_now && !counter_clear) |=> (count == '0) && wrap_flag;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("no wrap to zero");

  property p_step;
    @(posedge sys_clk) disable iff (!nrst)
      (run && !wrap_now && !counter_clear) |=> count == $past(count) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("count did not step");

  property p_toggle;
    @(posedge sys_clk) disable iff (!nrst)
      (wrap_now && channel_zero_control.toggle_on_wrap && !m0 &&
       !channel_zero_control.full_duty_force) |=> channel_zero_pin != $past(channel_zero_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");

  property p_clear;
    @(posedge sys_clk) disable iff (!nrst)
      (m0 && channel_zero_control.edge_action_high && !channel_zero_control.edge_action_low
       && !channel_zero_control.full_duty_force) |=> !channel_zero_pin;
  endproperty
  a_clear: assert property (p_clear) else $error("pin not cleared");

  // compare event once the counter reaches the value
  property p_event;
    @(posedge sys_clk) disable iff (!nrst)
      (run && !wrap_now && !counter_clear && (count + 1'b1 == cmp_zero)) |=> cmp0_event;
  endproperty
  a_event: assert property (p_event) else $error("compare event missing");

  property p_swap;
    @(posedge sys_clk) disable iff (!nrst)
      (linked && wrap_now && !value0_written && (value1_written || pending == ACT_ONE))
        |=> set_one_active;
  endproperty
  a_swap: assert property (p_swap) else $error("set one not taken at wrap");

  // while linked, the active set moves only at a wrap
  property p_hold;
    @(posedge sys_clk) disable iff (!nrst)
      (linked && !wrap_now) |=> set_one_active == $past(set_one_active);
  endproperty
  a_hold: assert property (p_hold) else $error("active set moved between wraps");

  property p_one_idle;
    @(posedge sys_clk) disable iff (!nrst)
      linked |-> !channel_one_pin_oe ##1 !cmp1_event;
  endproperty
  a_one_idle: assert property (p_one_idle) else $error("channel one active");

  property p_zero_duty;
    @(posedge sys_clk) disable iff (!nrst)
      (!channel_zero_control.toggle_on_wrap && !m0) |=> channel_zero_pin == $past(channel_zero_pin);
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("pin moved without event");
endmodule // timer_compare_pwm_channels
`default_nettype wire

// ### tb/pwm_load.sv
/*
  load model on a pwm pin: measures the last pulse width and period.
  assumes the pin only changes on sys_clk edges and lvl gives the pulse level.
*/
`default_nettype none
module pwm_load (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // observed pin
  input wire logic pin,
  input wire logic lvl,
  // last figures seen
  output logic [15:0] width,
  output logic [15:0] period
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  logic [15:0] run;
  logic [15:0] wid;
  // a steady pin leaves the old figures standing, so read them after a full period
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
      run <= 16'h0;
      wid <= 16'h0;
      width <= 16'h0;
      period <= 16'h0;
    end else begin
      prev <= pin;
      run <= run + 16'h1;
      wid <= wid + {15'h0, pin == lvl};
      if (pin == lvl && prev != lvl) begin
        period <= run;
        run <= 16'h1;
        wid <= 16'h1;
      end
      if (pin != lvl && prev == lvl) begin
        width <= wid;
      end
    end
  end
endmodule // pwm_load
`default_nettype wire

// ### tb/timer_compare_pwm_channels_test.sv
/*
  self-checking bench for the compare/pwm block: table of pwm setups, then
  unbuffered rewrite, linked set switching and the 0%/100% cases.
  assumes tick is driven here: every clock, or every second clock when slow is set.
*/
`default_nettype none
module timer_compare_pwm_channels_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pwm_pkg::*;
  typedef struct {logic [15:0] l; logic [15:0] v; logic [5:0] c; logic o;} row_s;
  logic sys_clk, nrst, halt, clr, w0, w1, p0, p1, oe1, wrap, e0, e1, linked, act1, lvl, s;
  logic tk, slow;
  logic [15:0] lim, v0, v1, cnt, wid, per;
  chan_ctrl_s c0, c1;
  int num_errors = 0;
  int tests_run = 0;
  int n, k;
  // limit, width, control bits, channel one pin enable expected
  row_s rows [5] = '{'{16'h3, 16'h1, 6'h1a, 1'b1}, '{16'h7, 16'h3, 6'h1e, 1'b1},
    '{16'h9, 16'h4, 6'h2a, 1'b0}, '{16'hf, 16'h8, 6'h1e, 1'b1}, '{16'h5, 16'h2, 6'h3a, 1'b0}};

  timer_compare_pwm_channels i_dut (.sys_clk(sys_clk), .nrst(nrst), .tick(tk),
    .counter_halt(halt), .counter_clear(clr), .period_limit(lim), .channel_value0(v0),
    .channel_value1(v1), .value1_written(w1), .value0_written(w0),
    .channel_zero_control(c0), .channel_one_control(c1), .channel_zero_pin(p0),
    .channel_one_pin(p1), .channel_one_pin_oe(oe1), .count(cnt), .wrap_flag(wrap),
    .cmp0_event(e0), .cmp1_event(e1), .pair_linked(linked), .set_one_active(act1));
  pwm_load u_load (.sys_clk(sys_clk), .nrst(nrst), .pin(p0), .lvl(lvl), .width(wid),
    .period(per));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // prescale by two when slow is set, otherwise count on every clock
  always @(negedge sys_clk) begin
    tk <= slow ? ~tk : 1'b1;
  end

  task automatic conclude();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check1(input logic got, input logic exp);
    check16({15'h0, got}, {15'h0, exp});
  endtask
  task automatic cyc(input int m);
    repeat (m) @(negedge sys_clk);
  endtask
  // cycles until the next wrap pulse, bounded
  task automatic to_wrap(output int m);
    m = 0;
    do begin
      @(negedge sys_clk);
      m++;
    end while (wrap !== 1'b1 && m < 1000);
  endtask
  // compare pulses on channel zero up to the next wrap
  task automatic count_e0(output int m);
    int t;
    m = 0;
    t = 0;
    do begin
      @(negedge sys_clk);
      m += int'(e0 === 1'b1);
      t++;
    end while (wrap !== 1'b1 && t < 1000);
  endtask
  // channel one events and any high level up to the next wrap
  task automatic watch_one(output int m, output logic hi);
    int t;
    m = 0;
    hi = 1'b0;
    t = 0;
    do begin
      @(negedge sys_clk);
      m += int'(e1 === 1'b1);
      hi = hi | (p1 === 1'b1);
      t++;
    end while (wrap !== 1'b1 && t < 1000);
  endtask
  // wait for a given count, bounded
  task automatic to_count(input logic [15:0] c);
    int t;
    t = 0;
    while (cnt !== c && t < 40) begin
      cyc(1);
      t++;
    end
  endtask
  // halt, clear, setup, release
  // edge codes used are clear or set only, never toggle on compare
  task automatic cfg(input logic [15:0] l, input logic [15:0] v, input logic [5:0] c);
    halt = 1'b1;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    lim = l;
    v0 = v;
    c0 = c;
    lvl = ~c[2];
    cyc(1);
    halt = 1'b0;
  endtask

  initial begin
    nrst = 1'b0;
    {halt, clr, w0, w1, lvl, slow} = 6'h20;
    {lim, v0, v1} = 48'h1;
    c0 = 6'h1a;
    c1 = 6'h1a;
    cyc(3);
    check16(cnt, 16'h0);
    check1(p0 | wrap | e0, 1'b0);
    nrst = 1'b1;
    // channel one runs a width of one on the same counter unless linked
    foreach (rows[i]) begin
      cfg(rows[i].l, rows[i].v, rows[i].c);
      cyc(3 * (int'(rows[i].l) + 1) + 4);
      // the first wait lines up on a wrap, the second spans one whole period
      to_wrap(n);
      to_wrap(n);
      check16(16'(n), rows[i].l + 16'h1);
      check16(per, rows[i].l + 16'h1);
      check16(wid, rows[i].v);
      check1(oe1, rows[i].o);
      check1(linked, ~rows[i].o);
      watch_one(k, s);
      check16(16'(k), {15'h0, rows[i].o});
      // a released pin may hold any level, so only a driven one is looked at
      if (rows[i].o) begin
        check1(s, 1'b1);
      end
    end
    // counting every second clock doubles period and width in bus clocks
    slow = 1'b1;
    cfg(16'h3, 16'h1, 6'h1a);
    cyc(20);
    to_wrap(n);
    to_wrap(n);
    check16(16'(n), 16'h8);
    check16(per, 16'h8);
    check16(wid, 16'h2);
    slow = 1'b0;
    // unbuffered rewrite between new and old value: no compare this period
    cfg(16'hf, 16'ha, 6'h1a);
    to_wrap(n);
    to_count(16'h7);
    v0 = 16'h5;
    count_e0(k);
    check16(16'(k), 16'h0);
    count_e0(k);
    check16(16'(k), 16'h1);
    cyc(20);
    check16(wid, 16'h5);
    // smaller value written after this period's compare
    to_wrap(n);
    to_count(16'h8);
    v0 = 16'h3;
    count_e0(k);
    check16(16'(k), 16'h0);
    count_e0(k);
    check16(16'(k), 16'h1);
    check16(wid, 16'h3);
    // larger value written at the wrap serves the period just begun
    v0 = 16'h9;
    count_e0(k);
    check16(16'(k), 16'h1);
    check16(wid, 16'h9);
    // linked pair: set one written only while set zero drives the pin
    cfg(16'h9, 16'h2, 6'h2a);
    v1 = 16'h6;
    cyc(25);
    check16(wid, 16'h2);
    to_wrap(n);
    cyc(2);
    w1 = 1'b1;
    cyc(1);
    w1 = 1'b0;
    check1(act1, 1'b0);
    to_wrap(n);
    cyc(1);
    check1(act1, 1'b1);
    cyc(25);
    check16(wid, 16'h6);
    w0 = 1'b1;
    cyc(1);
    w0 = 1'b0;
    to_wrap(n);
    cyc(1);
    check1(act1, 1'b0);
    // no wrap toggle holds the pin low, forced duty holds it at pulse level
    cfg(16'h7, 16'h3, 6'h18);
    cyc(10);
    s = 1'b0;
    repeat (24) begin
      cyc(1);
      s = s | p0;
    end
    check1(s, 1'b0);
    cfg(16'h7, 16'h3, 6'h1b);
    cyc(10);
    s = 1'b1;
    repeat (24) begin
      cyc(1);
      s = s & p0;
    end
    check1(s, 1'b1);
    conclude();
  end

  // hang guard, well beyond the several hundred cycles the sequence needs
  initial begin
    #160000;
    num_errors++;
    conclude();
  end
endmodule // timer_compare_pwm_channels_test
`default_nettype wire
